// ==== src/ldi_i2c_defs.vh ====
// constants for the led driver i2c target port
`ifndef LDI_I2C_DEFS_VH
`define LDI_I2C_DEFS_VH
`define LDI_DEV_ADDR 7'h27
`define LDI_BYTE_BITS 4'h8
`define LDI_ACK_BIT 4'h8
`define LDI_ACK_DONE 4'h9
`define LDI_DIR_READ 1'b1
`define LDI_EN_WAIT_NS 100000
`define LDI_CLK_NS 5
`endif

// ==== src/ldi_i2c_target.v ====
// i2c target port of the led driver
//Contract
//- sda fall/rise with scl high: start/stop
//- busy from start until stop
//- repeated start restarts address phase
//- sda changes only while scl low
//- eight bits msb first, then ack
//- target pulls sda low on ninth clock
//- high sda on ack clock is nack
//- first byte is address plus direction
//- mismatch: ignore bus until next start
//- own address is 27h
//- address lsb zero write, one read
//- write: address, pointer, one data, stop
//- interrupted byte is discarded
//- target drives pointed register data in read
//- written value applies after eighth bit
`timescale 1ns/1ps
`include "ldi_i2c_defs.vh"
module ldi_i2c_target #(
    parameter EN_WAIT_CYCLES = (`LDI_EN_WAIT_NS + `LDI_CLK_NS - 1) / `LDI_CLK_NS
) (
    input wire mclk,
    input wire reset_n,
    input wire enable,
    input wire sclIn,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    output wire busBusy,
    output reg [7:0] wrAddr,
    output reg [7:0] wrData,
    output wire wrValid,
    input wire wrReady,
    output reg [7:0] rdAddr,
    output wire rdReq,
    input wire [7:0] rdData
);
    // ************
    // reset and input synchronisers
    // ************
    reg rstA;
    reg rstB;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstA <= 1'b0;
            rstB <= 1'b0;
        end else begin
            rstA <= 1'b1;
            rstB <= rstA;
        end
    end
    wire rstN = rstB;
    reg [1:0] sclSync;
    reg [1:0] sdaSync;
    reg [1:0] enSync;
    reg sclPrev;
    reg sdaPrev;
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            enSync <= 2'h0;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclSync <= {sclSync[0], sclIn};
            sdaSync <= {sdaSync[0], sdaIn};
            enSync <= {enSync[0], enable};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end
    wire scl = sclSync[1];
    wire sda = sdaSync[1];
    wire en = enSync[1];
    wire sclRise = scl & ~sclPrev;
    wire sclFall = ~scl & sclPrev;
    wire startCond = scl & sclPrev & sdaPrev & ~sda;
    wire stopCond = scl & sclPrev & ~sdaPrev & sda;

    // ************
    // enable settle timer
    // ************
    reg [17:0] enCnt;
    reg portOn;
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            enCnt <= 18'h00000;
            portOn <= 1'b0;
        end else if (!en) begin
            enCnt <= 18'h00000;
            portOn <= 1'b0;
        end else if (enCnt == EN_WAIT_CYCLES[17:0] - 18'h00001) begin
            portOn <= 1'b1;
        end else begin
            enCnt <= enCnt + 18'h00001;
        end
    end

    // ************
    // two-entry write buffer
    // ************
    reg [15:0] buf0;
    reg [15:0] buf1;
    reg [1:0] bufCnt;
    reg pushReq;
    reg [15:0] pushWord;
    wire bufReady = (bufCnt != 2'h2);
    wire popReady = wrReady;
    assign wrValid = (bufCnt != 2'h0);
    always @* begin
        wrAddr = buf0[15:8];
        wrData = buf0[7:0];
    end
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            buf0 <= 16'h0000;
            buf1 <= 16'h0000;
            bufCnt <= 2'h0;
        end else begin
            case ({pushReq & bufReady, wrValid & popReady})
                2'b10: begin
                    if (bufCnt == 2'h0) buf0 <= pushWord;
                    else buf1 <= pushWord;
                    bufCnt <= bufCnt + 2'h1;
                end
                2'b01: begin
                    buf0 <= buf1;
                    bufCnt <= bufCnt - 2'h1;
                end
                2'b11: begin
                    if (bufCnt == 2'h1) buf0 <= pushWord;
                    else begin
                        buf0 <= buf1;
                        buf1 <= pushWord;
                    end
                end
                default: begin
                    bufCnt <= bufCnt;
                end
            endcase
        end
    end

    // ************
    // protocol decode
    // ************
    localparam IDLE = 6'h01;
    localparam ADDR = 6'h02;
    localparam PTR = 6'h04;
    localparam DATA = 6'h08;
    localparam READ = 6'h10;
    localparam HOLD = 6'h20;
    reg [5:0] state;
    reg [3:0] bitCnt;
    reg [7:0] shift;
    reg ackDrive;
    reg txDrive;
    reg busy;
    reg readReq;
    reg masterNack;
    reg giveAck;
    wire bitPhase = (bitCnt < `LDI_BYTE_BITS);
    wire byteEnd = sclFall & (bitCnt == `LDI_BYTE_BITS);
    wire ackRise = sclRise & (bitCnt == `LDI_ACK_BIT);
    wire ackEnd = sclFall & (bitCnt == `LDI_ACK_DONE);
    wire addrMatch = (shift[7:1] == `LDI_DEV_ADDR);
    wire dirRead = (shift[0] == `LDI_DIR_READ);
    wire readStart = ackEnd & (state == ADDR) & ackDrive & dirRead;
    wire txShift = sclFall & (bitCnt != 4'h0) & bitPhase;
    wire lineReset = ~portOn | startCond | stopCond;
    assign sdaOut = 1'b0;
    assign sdaOe = ackDrive | txDrive;
    assign busBusy = busy;
    assign rdReq = readReq;
    always @* begin
        case (state)
            ADDR: giveAck = addrMatch;
            PTR: giveAck = 1'b1;
            DATA: giveAck = bufReady;
            default: giveAck = 1'b0;
        endcase
    end

    // ************
    // bus and protocol state
    // ************
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            busy <= 1'b0;
        end else if (!portOn) begin
            busy <= 1'b0;
        end else if (startCond) begin
            busy <= 1'b1;
        end else if (stopCond) begin
            busy <= 1'b0;
        end
    end
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state <= IDLE;
        end else if (!portOn) begin
            state <= IDLE;
        end else if (startCond) begin
            state <= ADDR;
        end else if (stopCond) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE: begin
                    state <= IDLE;
                end
                ADDR: begin
                    if (ackEnd && !ackDrive) begin
                        state <= IDLE;
                    end else if (ackEnd && dirRead) begin
                        state <= READ;
                    end else if (ackEnd) begin
                        state <= PTR;
                    end
                end
                PTR: begin
                    if (ackEnd) begin
                        state <= DATA;
                    end
                end
                DATA: begin
                    if (ackEnd) begin
                        state <= HOLD;
                    end
                end
                READ: begin
                    if (ackEnd && masterNack) begin
                        state <= IDLE;
                    end
                end
                HOLD: begin
                    state <= HOLD;
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // ************
    // bit counter and shifter
    // ************
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            bitCnt <= 4'h0;
        end else if (lineReset || state == IDLE) begin
            bitCnt <= 4'h0;
        end else if (sclRise && bitPhase) begin
            bitCnt <= bitCnt + 4'h1;
        end else if (ackRise) begin
            bitCnt <= `LDI_ACK_DONE;
        end else if (ackEnd) begin
            bitCnt <= 4'h0;
        end
    end
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            shift <= 8'h00;
        end else if (readStart || (state == READ && ackEnd)) begin
            shift <= rdData;
        end else if (state == READ && txShift) begin
            shift <= {shift[6:0], 1'b1};
        end else if (state != READ && sclRise && bitPhase) begin
            shift <= {shift[6:0], sda};
        end
    end

    // ************
    // sda drive
    // ************
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txDrive <= 1'b0;
        end else if (lineReset) begin
            txDrive <= 1'b0;
        end else if (readStart) begin
            txDrive <= ~rdData[7];
        end else if (state != READ) begin
            txDrive <= 1'b0;
        end else if (ackEnd) begin
            txDrive <= ~masterNack & ~rdData[7];
        end else if (byteEnd) begin
            txDrive <= 1'b0;
        end else if (txShift) begin
            txDrive <= ~shift[6];
        end
    end
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ackDrive <= 1'b0;
        end else if (lineReset) begin
            ackDrive <= 1'b0;
        end else if (byteEnd && giveAck) begin
            ackDrive <= 1'b1;
        end else if (ackEnd) begin
            ackDrive <= 1'b0;
        end
    end
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            masterNack <= 1'b0;
        end else if (lineReset) begin
            masterNack <= 1'b0;
        end else if (state == READ && ackRise) begin
            masterNack <= sda;
        end
    end

    // ************
    // read request, pointer and write push
    // ************
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rdAddr <= 8'h00;
            readReq <= 1'b0;
        end else begin
            readReq <= byteEnd & (state == ADDR) & addrMatch & dirRead;
            if (ackEnd && state == PTR && ackDrive) begin
                rdAddr <= shift;
            end
        end
    end
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pushReq <= 1'b0;
            pushWord <= 16'h0000;
        end else if (byteEnd && state == DATA && bufReady) begin
            pushReq <= 1'b1;
            pushWord <= {rdAddr, shift};
        end else if (bufReady) begin
            pushReq <= 1'b0;
        end
    end
endmodule

// ==== tb/ldi_i2c_properties.sv ====
// assertion checker for the i2c target port
`timescale 1ns/1ps
module ldi_i2c_properties (
    input wire mclk,
    input wire reset_n,
    input wire sclIn,
    input wire sdaIn,
    input wire sdaOe,
    input wire busBusy,
    input wire [7:0] wrAddr,
    input wire [7:0] wrData,
    input wire wrValid,
    input wire wrReady,
    input wire rdReq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    sequence startSeen;
        sclIn && $fell(sdaIn);
    endsequence
    sequence stopSeen;
        sclIn && $rose(sdaIn);
    endsequence
    start_busy_a: assert property (startSeen |-> ##[1:8] busBusy)
        else $error("bus not busy after start");
    stop_free_a: assert property (stopSeen |-> ##[1:8] !busBusy)
        else $error("bus not free after stop");
    oe_scl_low_a: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("sda drive changed with scl high");
    idle_no_oe_a: assert property (!busBusy |-> !sdaOe)
        else $error("sda driven on free bus");
    wr_hold_a: assert property (wrValid && !wrReady |=> wrValid && $stable({wrAddr, wrData}))
        else $error("write entry lost under stall");
    push_busy_a: assert property ($rose(wrValid) |-> busBusy)
        else $error("write entry outside transaction");
    rd_pulse_a: assert property (rdReq |=> !rdReq [*8])
        else $error("read request not a single pulse");
    rd_busy_a: assert property (rdReq |-> busBusy)
        else $error("read request on free bus");
endmodule

// ==== tb/ldi_ctrl_model.sv ====
// i2c bus controller model
`timescale 1ns/1ps
module ldi_ctrl_model (
    output reg scl,
    output reg sdaLow,
    input wire sdaLine
);
    localparam real HALF = 62.5;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task startCond;
        begin
            sdaLow = 1'b0;
            #HALF scl = 1'b1;
            #HALF sdaLow = 1'b1;
            #HALF scl = 1'b0;
        end
    endtask
    task stopCond;
        begin
            #HALF sdaLow = 1'b1;
            #HALF scl = 1'b1;
            #HALF sdaLow = 1'b0;
            #HALF;
        end
    endtask
    task clockBit(input bit drive, output bit seen);
        begin
            #20 sdaLow = ~drive;
            #(HALF - 20) scl = 1'b1;
            #HALF seen = sdaLine;
            scl = 1'b0;
        end
    endtask
    task xferByte(input [7:0] tx, input int n, input bit ackOut, output logic [7:0] rx, output bit ack);
        bit b;
        begin
            for (int i = 7; i > 7 - n; i--) begin
                clockBit(tx[i], b);
                rx[i] = b;
            end
            if (n == 8) clockBit(ackOut, ack);
        end
    endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the i2c target port
`timescale 1ns/1ps
module tb;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg enable = 1'b0;
    reg wrReady = 1'b0;
    wire scl, sdaLow, sdaOut, sdaOe, busBusy, wrValid, rdReq;
    wire [7:0] wrAddr, wrData, rdAddr, rdData;
    wire sdaLine = ~sdaLow & (~sdaOe | sdaOut);
    reg [7:0] regs [0:255];
    logic [15:0] expQ [$];
    logic [7:0] p, d, rx;
    bit ack, hold;
    int bad_count = 0;
    int n_tests = 0;
    assign rdData = regs[rdAddr];
    ldi_i2c_target #(.EN_WAIT_CYCLES(10)) i_ldi_i2c_target (.mclk(mclk), .reset_n(reset_n), .enable(enable),
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .busBusy(busBusy), .wrAddr(wrAddr),
        .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady), .rdAddr(rdAddr), .rdReq(rdReq), .rdData(rdData));
    ldi_ctrl_model i_ctrl (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task check(input logic [15:0] got, input logic [15:0] exp);
        begin
            n_tests++;
            if (got !== exp) begin
                bad_count++;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("tests %0d errors %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        wrReady <= #1 ~hold & 1'($urandom);
        if (wrValid === 1'b1 && wrReady) check({wrAddr, wrData}, expQ.size() ? expQ.pop_front() : 16'hXXXX);
    end
    task wrTxn(input [7:0] dev, input int n, input [2:0] e);
        logic [2:0] a;
        begin
            i_ctrl.startCond();
            i_ctrl.xferByte(dev, 8, 1'b1, rx, a[2]);
            i_ctrl.xferByte(p, 8, 1'b1, rx, a[1]);
            i_ctrl.xferByte(d, n, 1'b1, rx, a[0]);
            if (n < 8) a[0] = e[0];
            check(16'(a), 16'(e));
            i_ctrl.stopCond();
            check(16'(busBusy), 16'h0000);
        end
    endtask
    task rdTxn(input bit viaStop);
        logic [2:0] a;
        begin
            i_ctrl.startCond();
            i_ctrl.xferByte(8'h4E, 8, 1'b1, rx, a[2]);
            i_ctrl.xferByte(p, 8, 1'b1, rx, a[1]);
            if (viaStop) i_ctrl.stopCond();
            i_ctrl.startCond();
            i_ctrl.xferByte(8'h4F, 8, 1'b1, rx, a[0]);
            check(16'(a), 16'h0000);
            check(16'(rdAddr), 16'(p));
            i_ctrl.xferByte(8'hFF, 8, 1'b0, rx, ack);
            check(16'(rx), 16'(regs[p]));
            i_ctrl.xferByte(8'hFF, 8, 1'b1, rx, ack);
            check(16'(rx), 16'(regs[p]));
            i_ctrl.stopCond();
        end
    endtask
    initial begin
        void'($urandom(32'h550F));
        for (int i = 0; i < 256; i++) regs[i] = $urandom;
        repeat (10) @(posedge mclk);
        #1 reset_n = 1'b1;
        enable = 1'b1;
        repeat (20) @(posedge mclk);
        for (int k = 0; k < 7; k++) begin
            p = $urandom;
            d = $urandom;
            hold = k > 3;
            if (k != 6) expQ.push_back({p, d});
            wrTxn(8'h4E, 8, {2'b00, k == 6});
        end
        hold = 1'b0;
        wrTxn({7'h27 ^ 7'($urandom_range(1, 127)), 1'b0}, 8, 3'b111);
        wrTxn(8'h4E, 4, 3'b000);
        p = $urandom;
        rdTxn(1'b0);
        p = $urandom;
        rdTxn(1'b1);
        for (int w = 0; w < 100 && expQ.size() > 0; w++) @(posedge mclk);
        check(16'(expQ.size()), 16'h0000);
        complete_run();
    end
    initial begin
        #300000;
        bad_count++;
        complete_run();
    end
endmodule
bind ldi_i2c_target ldi_i2c_properties i_props (.mclk(mclk), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOe(sdaOe), .busBusy(busBusy), .wrAddr(wrAddr), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
    .rdReq(rdReq));
